// ---- shared/swrc_pkg.sv ----
package swrc_pkg;
    // APB register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_LEVEL = 8'h04;
    localparam logic [7:0] OFF_STEP = 8'h08;
    localparam logic [7:0] OFF_DELAY = 8'h0c;
    localparam logic [7:0] OFF_HILIM = 8'h10;
    localparam logic [7:0] OFF_LOLIM = 8'h14;
    localparam logic [7:0] OFF_RATIO = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
    localparam logic [7:0] OFF_CAP_IN = 8'h28;
    localparam logic [7:0] OFF_RESULT = 8'h2c;
    localparam logic [7:0] OFF_DEVCLR = 8'h30;
    // Waveform codes
    localparam logic [1:0] WAVE_OFF = 2'h0;
    localparam logic [1:0] WAVE_DC = 2'h1;
    localparam logic [1:0] WAVE_SQUARE = 2'h2;
    localparam logic [1:0] WAVE_STAIR = 2'h3;
    // Ratio codes
    localparam logic [1:0] RATIO_OFF = 2'h0;
    localparam logic [1:0] RATIO_ON = 2'h1;
    localparam logic [1:0] RATIO_STORE = 2'h2;
    // Levels in mV, signed 16 bit
    localparam logic signed [15:0] LEVEL_MIN_MV = -16'sd20000;
    localparam logic signed [15:0] LEVEL_MAX_MV = 16'sd20000;
    localparam logic signed [15:0] LEVEL_RST_MV = 16'sd0;
    localparam logic [2:0] STEP_RST = 3'h2;
    // Delay in hundredths of a second
    localparam logic [14:0] DELAY_MIN_CS = 15'd7;
    localparam logic [14:0] DELAY_MAX_CS = 15'd19999;
    localparam logic [14:0] DELAY_EXTRA_CS = 15'd4;
    localparam int CLK_HZ = 100000000;
    localparam int CS_PER_SEC = 100;
    localparam int CYC_PER_CS = CLK_HZ / CS_PER_SEC;
    // Interrupt bits
    localparam int IRQ_STEP = 0;
    localparam int IRQ_STAIR_DONE = 1;
    localparam int IRQ_CONFLICT = 2;
    localparam int IRQ_RESULT = 3;
    localparam int IRQ_W = 4;
    localparam logic [31:0] OVERRANGE = 32'hffffffff;
    localparam int FRAC_BITS = 16;
endpackage : swrc_pkg

// ---- core/swrc_ctrl.sv ----
`timescale 1ns/100ps
// How it works
// - Off selection drives zero volts
// - DC holds programmed level
// - Square alternates by step, dwell plus 0.04s
// - Staircase adds signed step each dwell
// - Staircase stops at limit, becomes DC
// - Reset or clear selects square wave
// - DC freezes staircase; reselect resumes
// - Ratio on divides capacitance by reference
// - No reference stored gives overrange
// - Store code captures next capacitance reading
// - Reset or clear: ratio off, unstored
// - Current value is never divided
// - Ratio command in current function: conflict
// - Level spans minus to plus twenty volts
// - Delay accepts 0.07 to 199.99 seconds
// - Step defaults to plus 50 mV
// - Low limit defaults to minus twenty volts
module swrc_ctrl #(
    parameter int CYC_PER_CS = swrc_pkg::CYC_PER_CS
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CUR_FUNC,
    input wire logic CAP_VALID,
    input wire logic [31:0] CAP_VALUE,
    input wire logic [31:0] CUR_VALUE,
    output logic signed [15:0] SRC_MV,
    output logic [31:0] CAP_RESULT,
    output logic [31:0] CUR_RESULT,
    output logic RESULT_VALID,
    output logic IRQ
);
    typedef enum logic [1:0] {SWRC_IDLE, SWRC_DIV} swrc_div_t;
    function automatic logic signed [15:0] step_mv(input logic [2:0] code);
        logic signed [15:0] mag;
        case (code[1:0])
            2'h0: mag = 16'sd10;
            2'h1: mag = 16'sd20;
            2'h2: mag = 16'sd50;
            default: mag = 16'sd100;
        endcase
        return code[2] ? -mag : mag;
    endfunction : step_mv
    // Clamp on the full signed word so large writes do not wrap
    function automatic logic signed [15:0] clamp_lv(input logic [31:0] d);
        if ($signed(d) > 32'(swrc_pkg::LEVEL_MAX_MV)) return swrc_pkg::LEVEL_MAX_MV;
        if ($signed(d) < 32'(swrc_pkg::LEVEL_MIN_MV)) return swrc_pkg::LEVEL_MIN_MV;
        return d[15:0];
    endfunction : clamp_lv
    logic [1:0] wave_r, wave_nxt;
    logic signed [15:0] level_r, level_nxt, hilim_r, hilim_nxt, lolim_r, lolim_nxt;
    logic [2:0] step_r, step_nxt;
    logic [14:0] delay_r, delay_nxt;
    logic ratio_on_r, ratio_on_nxt, ref_ok_r, ref_ok_nxt, store_r, store_nxt;
    logic [31:0] ref_r, ref_nxt;
    logic signed [15:0] stair_r, stair_nxt, src_r, src_nxt;
    logic stair_act_r, stair_act_nxt, sq_hi_r, sq_hi_nxt;
    logic [31:0] cyc_r, cyc_nxt;
    logic [14:0] cs_r, cs_nxt;
    logic [swrc_pkg::IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt;
    logic [31:0] prdata_r, prdata_nxt, cap_res_r, cap_res_nxt, cur_res_r, cur_res_nxt;
    logic res_v_r, res_v_nxt;
    swrc_div_t dst_r, dst_nxt;
    logic [63:0] rem_r, rem_nxt, trial, dvs;
    logic [47:0] quo_r, quo_nxt;
    logic [5:0] bit_r, bit_nxt;
    logic wr, rd, devclr, dwell_end, step_ev, done_ev, conflict_ev, res_ev;
    logic signed [16:0] next_stair;
    logic signed [15:0] stp;
    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && !PENABLE && !PWRITE;
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
    assign PRDATA = prdata_r;
    assign SRC_MV = src_r;
    assign CAP_RESULT = cap_res_r;
    assign CUR_RESULT = cur_res_r;
    assign RESULT_VALID = res_v_r;
    assign IRQ = |(ist_r & imask_r);
    assign devclr = wr && PADDR == swrc_pkg::OFF_DEVCLR && PWDATA[0];
    assign stp = step_mv(step_r);
    assign next_stair = 17'(stair_r) + 17'(stp);
    assign dwell_end = cyc_r == 32'(CYC_PER_CS - 1) &&
        cs_r == delay_r + swrc_pkg::DELAY_EXTRA_CS - 15'd1;
    assign dvs = {32'h0, ref_r} << bit_r;
    assign trial = rem_r - dvs;
    always_comb begin
        wave_nxt = wave_r;
        level_nxt = level_r;
        hilim_nxt = hilim_r;
        lolim_nxt = lolim_r;
        step_nxt = step_r;
        delay_nxt = delay_r;
        ratio_on_nxt = ratio_on_r;
        ref_ok_nxt = ref_ok_r;
        store_nxt = store_r;
        ref_nxt = ref_r;
        stair_nxt = stair_r;
        stair_act_nxt = stair_act_r;
        sq_hi_nxt = sq_hi_r;
        cyc_nxt = cyc_r + 32'd1;
        cs_nxt = cs_r;
        imask_nxt = imask_r;
        step_ev = 1'b0;
        done_ev = 1'b0;
        conflict_ev = 1'b0;
        res_ev = 1'b0;
        if (cyc_r == 32'(CYC_PER_CS - 1)) begin
            cyc_nxt = 32'd0;
            cs_nxt = cs_r + 15'd1;
        end
        if (dwell_end) begin
            cs_nxt = 15'd0;
            step_ev = wave_r == swrc_pkg::WAVE_SQUARE || wave_r == swrc_pkg::WAVE_STAIR;
            sq_hi_nxt = !sq_hi_r;
            if (wave_r == swrc_pkg::WAVE_STAIR) begin
                if (next_stair > 17'(hilim_r) || next_stair < 17'(lolim_r)) begin
                    wave_nxt = swrc_pkg::WAVE_DC;
                    stair_act_nxt = 1'b0;
                    level_nxt = stair_r;
                    done_ev = 1'b1;
                end else begin
                    stair_nxt = next_stair[15:0];
                end
            end
        end
        if (wr) begin
            unique case (PADDR)
                swrc_pkg::OFF_CTRL: begin
                    wave_nxt = PWDATA[1:0];
                    cs_nxt = 15'd0;
                    cyc_nxt = 32'd0;
                    sq_hi_nxt = 1'b0;
                    if (PWDATA[1:0] == swrc_pkg::WAVE_STAIR && !stair_act_r) begin
                        stair_nxt = level_r;
                        stair_act_nxt = 1'b1;
                    end
                    if (PWDATA[1:0] == swrc_pkg::WAVE_DC && stair_act_r)
                        level_nxt = stair_r;
                    if (PWDATA[1:0] != swrc_pkg::WAVE_DC && PWDATA[1:0] != swrc_pkg::WAVE_STAIR)
                        stair_act_nxt = 1'b0;
                end
                swrc_pkg::OFF_LEVEL: level_nxt = clamp_lv(PWDATA);
                swrc_pkg::OFF_STEP: step_nxt = PWDATA[2:0];
                swrc_pkg::OFF_DELAY: begin
                    delay_nxt = PWDATA[14:0];
                    if (PWDATA[14:0] < swrc_pkg::DELAY_MIN_CS)
                        delay_nxt = swrc_pkg::DELAY_MIN_CS;
                    if (PWDATA[14:0] > swrc_pkg::DELAY_MAX_CS)
                        delay_nxt = swrc_pkg::DELAY_MAX_CS;
                end
                swrc_pkg::OFF_HILIM: hilim_nxt = clamp_lv(PWDATA);
                swrc_pkg::OFF_LOLIM: lolim_nxt = clamp_lv(PWDATA);
                swrc_pkg::OFF_RATIO: begin
                    if (CUR_FUNC)
                        conflict_ev = 1'b1;
                    else begin
                        unique case (PWDATA[1:0])
                            swrc_pkg::RATIO_OFF: ratio_on_nxt = 1'b0;
                            swrc_pkg::RATIO_ON: ratio_on_nxt = 1'b1;
                            swrc_pkg::RATIO_STORE: store_nxt = 1'b1;
                            default: ;
                        endcase
                    end
                end
                swrc_pkg::OFF_IRQ_MASK: imask_nxt = PWDATA[swrc_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
        if (CAP_VALID && store_r) begin
            ref_nxt = CAP_VALUE;
            ref_ok_nxt = CAP_VALUE != 32'h0;
            store_nxt = 1'b0;
        end
        if (devclr) begin
            wave_nxt = swrc_pkg::WAVE_SQUARE;
            level_nxt = swrc_pkg::LEVEL_RST_MV;
            hilim_nxt = swrc_pkg::LEVEL_MAX_MV;
            lolim_nxt = swrc_pkg::LEVEL_MIN_MV;
            step_nxt = swrc_pkg::STEP_RST;
            delay_nxt = swrc_pkg::DELAY_MIN_CS;
            ratio_on_nxt = 1'b0;
            ref_ok_nxt = 1'b0;
            store_nxt = 1'b0;
            stair_act_nxt = 1'b0;
        end
    end

    // Bias source output
    always_comb begin
        unique case (wave_r)
            swrc_pkg::WAVE_OFF: src_nxt = 16'sd0;
            swrc_pkg::WAVE_DC: src_nxt = level_r;
            swrc_pkg::WAVE_SQUARE: src_nxt = sq_hi_r ? level_r + stp : level_r;
            swrc_pkg::WAVE_STAIR: src_nxt = stair_r;
        endcase
    end
    // Restoring divider for the ratio, 16 fractional bits
    always_comb begin
        dst_nxt = dst_r;
        rem_nxt = rem_r;
        quo_nxt = quo_r;
        bit_nxt = bit_r;
        cap_res_nxt = cap_res_r;
        cur_res_nxt = cur_res_r;
        res_v_nxt = 1'b0;
        unique case (dst_r)
            SWRC_IDLE: begin
                if (CAP_VALID) begin
                    cur_res_nxt = CUR_VALUE;
                    if (!ratio_on_r) begin
                        cap_res_nxt = CAP_VALUE;
                        res_v_nxt = 1'b1;
                    end else if (!ref_ok_r) begin
                        cap_res_nxt = swrc_pkg::OVERRANGE;
                        res_v_nxt = 1'b1;
                    end else begin
                        rem_nxt = {16'h0, CAP_VALUE, 16'h0};
                        quo_nxt = 48'h0;
                        bit_nxt = 6'd47;
                        dst_nxt = SWRC_DIV;
                    end
                end
            end
            SWRC_DIV: begin
                if (rem_r >= dvs && (dvs >> bit_r) == {32'h0, ref_r}) begin
                    rem_nxt = trial;
                    quo_nxt = quo_r | (48'h1 << bit_r);
                end
                bit_nxt = bit_r - 6'd1;
                if (bit_r == 6'd0) begin
                    dst_nxt = SWRC_IDLE;
                    res_v_nxt = 1'b1;
                    cap_res_nxt = (|quo_nxt[47:32]) ? swrc_pkg::OVERRANGE : quo_nxt[31:0];
                end
            end
            default: dst_nxt = SWRC_IDLE;
        endcase
    end

    // Sticky status, set wins over write-one clear
    always_comb begin
        ist_nxt = ist_r;
        if (wr && PADDR == swrc_pkg::OFF_IRQ_STAT)
            ist_nxt = ist_r & ~PWDATA[swrc_pkg::IRQ_W-1:0];
        if (step_ev) ist_nxt[swrc_pkg::IRQ_STEP] = 1'b1;
        if (done_ev) ist_nxt[swrc_pkg::IRQ_STAIR_DONE] = 1'b1;
        if (conflict_ev) ist_nxt[swrc_pkg::IRQ_CONFLICT] = 1'b1;
        if (res_v_nxt) ist_nxt[swrc_pkg::IRQ_RESULT] = 1'b1;
    end

    always_comb begin
        prdata_nxt = prdata_r;
        if (rd) begin
            unique case (PADDR)
                swrc_pkg::OFF_CTRL: prdata_nxt = {30'h0, wave_r};
                swrc_pkg::OFF_LEVEL: prdata_nxt = 32'(level_r);
                swrc_pkg::OFF_STEP: prdata_nxt = {29'h0, step_r};
                swrc_pkg::OFF_DELAY: prdata_nxt = {17'h0, delay_r};
                swrc_pkg::OFF_HILIM: prdata_nxt = 32'(hilim_r);
                swrc_pkg::OFF_LOLIM: prdata_nxt = 32'(lolim_r);
                swrc_pkg::OFF_RATIO: prdata_nxt = {29'h0, store_r, ref_ok_r, ratio_on_r};
                swrc_pkg::OFF_STATUS: prdata_nxt = {14'h0, stair_act_r, sq_hi_r, src_r};
                swrc_pkg::OFF_IRQ_STAT: prdata_nxt = 32'(ist_r);
                swrc_pkg::OFF_IRQ_MASK: prdata_nxt = 32'(imask_r);
                swrc_pkg::OFF_CAP_IN: prdata_nxt = ref_r;
                swrc_pkg::OFF_RESULT: prdata_nxt = cap_res_r;
                default: prdata_nxt = 32'h0;
            endcase
        end
    end
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wave_r <= swrc_pkg::WAVE_SQUARE;
            level_r <= swrc_pkg::LEVEL_RST_MV;
            hilim_r <= swrc_pkg::LEVEL_MAX_MV;
            lolim_r <= swrc_pkg::LEVEL_MIN_MV;
            step_r <= swrc_pkg::STEP_RST;
            delay_r <= swrc_pkg::DELAY_MIN_CS;
            ratio_on_r <= 1'b0;
            ref_ok_r <= 1'b0;
            store_r <= 1'b0;
            ref_r <= 32'h0;
            stair_r <= 16'sd0;
            stair_act_r <= 1'b0;
            sq_hi_r <= 1'b0;
            cyc_r <= 32'h0;
            cs_r <= 15'h0;
            ist_r <= '0;
            imask_r <= '0;
            prdata_r <= 32'h0;
            src_r <= 16'sd0;
            cap_res_r <= 32'h0;
            cur_res_r <= 32'h0;
            res_v_r <= 1'b0;
            dst_r <= SWRC_IDLE;
            rem_r <= 64'h0;
            quo_r <= 48'h0;
            bit_r <= 6'h0;
        end else begin
            wave_r <= wave_nxt;
            level_r <= level_nxt;
            hilim_r <= hilim_nxt;
            lolim_r <= lolim_nxt;
            step_r <= step_nxt;
            delay_r <= delay_nxt;
            ratio_on_r <= ratio_on_nxt;
            ref_ok_r <= ref_ok_nxt;
            store_r <= store_nxt;
            ref_r <= ref_nxt;
            stair_r <= stair_nxt;
            stair_act_r <= stair_act_nxt;
            sq_hi_r <= sq_hi_nxt;
            cyc_r <= cyc_nxt;
            cs_r <= cs_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            prdata_r <= prdata_nxt;
            src_r <= src_nxt;
            cap_res_r <= cap_res_nxt;
            cur_res_r <= cur_res_nxt;
            res_v_r <= res_v_nxt;
            dst_r <= dst_nxt;
            rem_r <= rem_nxt;
            quo_r <= quo_nxt;
            bit_r <= bit_nxt;
        end
    end
endmodule : swrc_ctrl

// ---- tb/swrc_host.sv ----
`timescale 1ns/100ps
module swrc_host (
    input wire logic clk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // One APB transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : swrc_host

// ---- tb/swrc_chk.sv ----
`timescale 1ns/100ps
module swrc_chk (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic CUR_FUNC,
    input wire logic CAP_VALID,
    input wire logic [31:0] CAP_VALUE,
    input wire logic [31:0] CUR_VALUE,
    input wire logic signed [15:0] SRC_MV,
    input wire logic [31:0] CAP_RESULT,
    input wire logic [31:0] CUR_RESULT,
    input wire logic RESULT_VALID
);
    default clocking dck @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);
    logic [1:0] wave_r;
    logic signed [15:0] lvl_r, step_r, hi_r, lo_r, mag;
    logic lok_r, rat_r, pend_r, ref_r, wr, clr;
    assign wr = PSEL && PENABLE && PWRITE;
    assign clr = wr && PADDR == swrc_pkg::OFF_DEVCLR && PWDATA[0];
    assign mag = PWDATA[1:0] == 2'h0 ? 16'sh000a : PWDATA[1:0] == 2'h1 ? 16'sh0014 :
        PWDATA[1:0] == 2'h2 ? 16'sh0032 : 16'sh0064;
    // Mirror of the settings written over the bus
    always_ff @(posedge REF_CLK) begin
        if (!RSTN || clr) begin
            wave_r <= swrc_pkg::WAVE_SQUARE;
            lvl_r <= swrc_pkg::LEVEL_RST_MV;
            step_r <= 16'sh0032;
            hi_r <= swrc_pkg::LEVEL_MAX_MV;
            lo_r <= swrc_pkg::LEVEL_MIN_MV;
            lok_r <= 1'b1;
            rat_r <= 1'b0;
            pend_r <= 1'b0;
            ref_r <= 1'b0;
        end else begin
            if (CAP_VALID && pend_r) begin
                pend_r <= 1'b0;
                ref_r <= CAP_VALUE != 32'h0;
            end
            if (wr) begin
                case (PADDR)
                    swrc_pkg::OFF_CTRL: wave_r <= PWDATA[1:0];
                    swrc_pkg::OFF_LEVEL: lvl_r <= PWDATA[15:0];
                    swrc_pkg::OFF_STEP: step_r <= PWDATA[2] ? -mag : mag;
                    swrc_pkg::OFF_HILIM: hi_r <= PWDATA[15:0];
                    swrc_pkg::OFF_LOLIM: lo_r <= PWDATA[15:0];
                    default: ;
                endcase
                if (PADDR == swrc_pkg::OFF_LEVEL)
                    lok_r <= 1'b1;
                if (PADDR == swrc_pkg::OFF_CTRL && PWDATA[1:0] == swrc_pkg::WAVE_STAIR)
                    lok_r <= 1'b0;
                if (PADDR == swrc_pkg::OFF_RATIO && !CUR_FUNC) begin
                    rat_r <= PWDATA[1:0] == swrc_pkg::RATIO_ON ? 1'b1 :
                        PWDATA[1:0] == swrc_pkg::RATIO_OFF ? 1'b0 : rat_r;
                    if (PWDATA[1:0] == swrc_pkg::RATIO_STORE)
                        pend_r <= 1'b1;
                end
            end
        end
    end
    sequence wave_wr_s(logic [1:0] w);
        wr && PADDR == swrc_pkg::OFF_CTRL && PWDATA[1:0] == w;
    endsequence
    sequence div_start_s;
        CAP_VALID && rat_r && ref_r && !pend_r;
    endsequence
    off_zero_a: assert property (wave_wr_s(swrc_pkg::WAVE_OFF) |-> ##[1:2] SRC_MV == 16'sh0)
        else $error("source not zero after off");
    dc_level_a: assert property (wave_wr_s(swrc_pkg::WAVE_DC) ##0 lok_r |-> ##[1:2] SRC_MV == lvl_r)
        else $error("source not at level after dc");
    square_values_a: assert property (wave_r == swrc_pkg::WAVE_SQUARE && lok_r && $changed(SRC_MV)
        |-> SRC_MV == lvl_r || SRC_MV == lvl_r + step_r) else $error("square value wrong");
    stair_step_a: assert property (wave_r == swrc_pkg::WAVE_STAIR && $changed(SRC_MV)
        |-> SRC_MV == lvl_r || SRC_MV - $past(SRC_MV) == step_r) else $error("stair step wrong");
    stair_limit_a: assert property (wave_r == swrc_pkg::WAVE_STAIR
        |-> SRC_MV <= hi_r && SRC_MV >= lo_r) else $error("stair beyond limit");
    raw_result_a: assert property (CAP_VALID && !rat_r && !pend_r
        |=> RESULT_VALID && CAP_RESULT == $past(CAP_VALUE)) else $error("raw result wrong");
    overrange_out_a: assert property (CAP_VALID && rat_r && !ref_r && !pend_r
        |=> RESULT_VALID && CAP_RESULT == swrc_pkg::OVERRANGE) else $error("overrange missing");
    current_copy_a: assert property (CAP_VALID |=> CUR_RESULT == $past(CUR_VALUE))
        else $error("current result changed");
    divide_time_a: assert property (div_start_s |-> ##[45:55] RESULT_VALID)
        else $error("quotient not ready in time");
endmodule : swrc_chk
bind swrc_ctrl swrc_chk u_swrc_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .CUR_FUNC(CUR_FUNC),
    .CAP_VALID(CAP_VALID), .CAP_VALUE(CAP_VALUE), .CUR_VALUE(CUR_VALUE), .SRC_MV(SRC_MV),
    .CAP_RESULT(CAP_RESULT), .CUR_RESULT(CUR_RESULT), .RESULT_VALID(RESULT_VALID));

// ---- tb/source_waveform_and_ratio_ctrl_test.sv ----
`timescale 1ns/100ps
module source_waveform_and_ratio_ctrl_test;
    logic REF_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic CUR_FUNC = 1'b0;
    logic CAP_VALID = 1'b0;
    logic [31:0] CAP_VALUE = 32'h0;
    logic [31:0] CUR_VALUE = 32'h0;
    logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, RESULT_VALID;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, CAP_RESULT, CUR_RESULT, q;
    logic signed [15:0] SRC_MV;
    logic signed [15:0] tab [8] = '{16'sh000a, 16'sh0014, 16'sh0032, 16'sh0064,
        -16'sh000a, -16'sh0014, -16'sh0032, -16'sh0064};
    int fails = 0;
    int total_checks = 0;
    int n;
    always #5 REF_CLK = ~REF_CLK;
    swrc_ctrl #(.CYC_PER_CS(10)) u_swrc_ctrl (
        .REF_CLK(REF_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .CUR_FUNC(CUR_FUNC), .CAP_VALID(CAP_VALID), .CAP_VALUE(CAP_VALUE),
        .CUR_VALUE(CUR_VALUE), .SRC_MV(SRC_MV), .CAP_RESULT(CAP_RESULT),
        .CUR_RESULT(CUR_RESULT), .RESULT_VALID(RESULT_VALID), .IRQ(IRQ));
    swrc_host u_swrc_host (.clk(REF_CLK), .prdata(PRDATA), .pready(PREADY), .psel(PSEL),
        .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR), .pwdata(PWDATA));
    task automatic conclude;
        if (fails == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask : cmp
    task automatic cmp_mv(input logic signed [15:0] e);
        cmp("source mV", 32'(e), 32'(SRC_MV));
    endtask : cmp_mv
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_swrc_host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        u_swrc_host.xfer(1'b0, a, 32'h0, q);
        cmp("register", e & m, q & m);
        cmp("slverr", 32'h0, 32'(PSLVERR));
    endtask : rd
    task automatic idle(input int k);
        repeat (k) @(negedge REF_CLK);
    endtask : idle
    // Cycles until the source output next moves
    task automatic wait_chg;
        logic signed [15:0] old;
        @(negedge REF_CLK);
        old = SRC_MV;
        n = 1;
        do begin
            @(negedge REF_CLK);
            n++;
        end while (SRC_MV === old && n < 3000);
    endtask : wait_chg
    task automatic cap(input logic [31:0] c, input logic [31:0] i, input logic [31:0] e);
        int k;
        @(posedge REF_CLK);
        CAP_VALID <= 1'b1;
        CAP_VALUE <= c;
        CUR_VALUE <= i;
        @(posedge REF_CLK);
        CAP_VALID <= 1'b0;
        CAP_VALUE <= ~c;
        k = 0;
        do begin
            @(negedge REF_CLK);
            k++;
        end while (RESULT_VALID !== 1'b1 && k < 100);
        cmp("cap result", e, CAP_RESULT);
        cmp("cur result", i, CUR_RESULT);
    endtask : cap
    initial begin
        repeat (16) @(posedge REF_CLK);
        RSTN <= 1'b1;
        rd(swrc_pkg::OFF_CTRL, 32'(swrc_pkg::WAVE_SQUARE), 32'h3);
        rd(swrc_pkg::OFF_STEP, 32'(swrc_pkg::STEP_RST), 32'h7);
        rd(swrc_pkg::OFF_LOLIM, 32'hffffb1e0, 32'hffff);
        rd(swrc_pkg::OFF_RATIO, 32'h0, 32'h7);
        rd(8'h3c, 32'h0, 32'hffffffff);
        wait_chg;
        cmp_mv(16'sh0032);
        wait_chg;
        cmp("square period", 32'h6e, 32'(n));
        wr(swrc_pkg::OFF_LEVEL, 32'h1388);
        wr(swrc_pkg::OFF_CTRL, 32'(swrc_pkg::WAVE_OFF));
        idle(3);
        cmp_mv(16'sh0);
        wr(swrc_pkg::OFF_CTRL, 32'(swrc_pkg::WAVE_DC));
        idle(300);
        cmp_mv(16'sh1388);
        wr(swrc_pkg::OFF_DELAY, 32'h3);
        rd(swrc_pkg::OFF_DELAY, 32'h7, 32'h7fff);
        wr(swrc_pkg::OFF_DELAY, 32'h4e20);
        rd(swrc_pkg::OFF_DELAY, 32'h4e1f, 32'h7fff);
        wr(swrc_pkg::OFF_DELAY, 32'h7);
        wr(swrc_pkg::OFF_LEVEL, 32'h0);
        for (int k = 0; k < 8; k++) begin
            wr(swrc_pkg::OFF_CTRL, 32'(swrc_pkg::WAVE_DC));
            wr(swrc_pkg::OFF_STEP, 32'(k));
            wr(swrc_pkg::OFF_CTRL, 32'(swrc_pkg::WAVE_SQUARE));
            wait_chg;
            cmp_mv(tab[k]);
        end
        wr(swrc_pkg::OFF_DELAY, 32'h14);
        wait_chg;
        wait_chg;
        cmp("square period", 32'hf0, 32'(n));
        wr(swrc_pkg::OFF_DELAY, 32'h7);
        wr(swrc_pkg::OFF_LEVEL, 32'h4d58);
        wr(swrc_pkg::OFF_STEP, 32'h3);
        wr(swrc_pkg::OFF_CTRL, 32'(swrc_pkg::WAVE_STAIR));
        idle(3);
        cmp_mv(16'sh4d58);
        wait_chg;
        cmp_mv(16'sh4dbc);
        wr(swrc_pkg::OFF_CTRL, 32'(swrc_pkg::WAVE_DC));
        idle(300);
        cmp_mv(16'sh4dbc);
        wr(swrc_pkg::OFF_CTRL, 32'(swrc_pkg::WAVE_STAIR));
        wait_chg;
        cmp_mv(16'sh4e20);
        idle(300);
        cmp_mv(16'sh4e20);
        rd(swrc_pkg::OFF_CTRL, 32'(swrc_pkg::WAVE_DC), 32'h3);
        rd(swrc_pkg::OFF_IRQ_STAT, 32'h2, 32'h2);
        wr(swrc_pkg::OFF_STEP, 32'h5);
        wr(swrc_pkg::OFF_LOLIM, 32'hffffb1fe);
        wr(swrc_pkg::OFF_LEVEL, 32'hffffb212);
        wr(swrc_pkg::OFF_CTRL, 32'(swrc_pkg::WAVE_STAIR));
        idle(400);
        cmp_mv(-16'sh4e02);
        wr(swrc_pkg::OFF_RATIO, 32'(swrc_pkg::RATIO_ON));
        cap(32'h3e8, 32'h5, swrc_pkg::OVERRANGE);
        wr(swrc_pkg::OFF_RATIO, 32'(swrc_pkg::RATIO_OFF));
        wr(swrc_pkg::OFF_RATIO, 32'(swrc_pkg::RATIO_STORE));
        cap(32'h2000, 32'h6, 32'h2000);
        rd(swrc_pkg::OFF_CAP_IN, 32'h2000, 32'hffffffff);
        wr(swrc_pkg::OFF_RATIO, 32'(swrc_pkg::RATIO_ON));
        cap(32'h4000, 32'h1234, 32'h20000);
        wr(swrc_pkg::OFF_RATIO, 32'(swrc_pkg::RATIO_OFF));
        cap(32'h309, 32'h7, 32'h309);
        wr(swrc_pkg::OFF_IRQ_MASK, 32'h4);
        @(posedge REF_CLK);
        CUR_FUNC <= 1'b1;
        wr(swrc_pkg::OFF_RATIO, 32'(swrc_pkg::RATIO_ON));
        rd(swrc_pkg::OFF_RATIO, 32'h0, 32'h1);
        idle(1);
        cmp("irq", 32'h1, 32'(IRQ));
        wr(swrc_pkg::OFF_IRQ_STAT, 32'h4);
        idle(1);
        cmp("irq", 32'h0, 32'(IRQ));
        @(posedge REF_CLK);
        CUR_FUNC <= 1'b0;
        wr(swrc_pkg::OFF_RATIO, 32'(swrc_pkg::RATIO_ON));
        wr(swrc_pkg::OFF_DEVCLR, 32'h1);
        rd(swrc_pkg::OFF_RATIO, 32'h0, 32'h7);
        rd(swrc_pkg::OFF_CTRL, 32'(swrc_pkg::WAVE_SQUARE), 32'h3);
        rd(swrc_pkg::OFF_STEP, 32'(swrc_pkg::STEP_RST), 32'h7);
        rd(swrc_pkg::OFF_LOLIM, 32'hffffb1e0, 32'hffff);
        conclude;
    end
    initial begin
        #200000;
        fails++;
        conclude;
    end
endmodule : source_waveform_and_ratio_ctrl_test
